//--- verilog/tll_regs.sv
// Remote low limit, security lock, result fraction and high limit fraction registers.
// ==========================================
// Overview of operation
// - Remote low limit whole degrees at 08h, two's complement, resets to zero.
// - Any limit register write purges and restarts that limit's fault queue.
// - Warm reset lockout set makes the configuration warm reset bit ignored.
// - Power-down lockout set refuses requests to enter shutdown.
// - Lock bits 2,1,0 lock diode, remote and local over-temperature events.
// - Result fraction in bits 7..4, sixteenths of a degree, low bits zero.
// - Read_Word at 01h returns whole byte then fraction, same conversion.
// - Read_Word only on result whole byte; all else Read_Byte.
// - Result fraction reads zero until the first conversion completes.
// - High limit fraction at 13h in bits 7..4, bits 3..0 read zero.
// - Security register read and written at command 09h.
// - Warm reset bit restores power-up defaults unless locked out.
// - Fault queue depth code 00,01,10,11 gives 1,2,4,6.
`timescale 1ns/100ps
`default_nettype none
module tll_regs (
   input wire logic mclk,
   input wire logic rst,
   input wire tll_pkg::tll_req_t req,
   input wire logic conv_done,
   input wire logic [7:0] conv_whole,
   input wire logic [3:0] conv_fraction,
   input wire tll_pkg::tll_evt_t evt_in,
   output tll_pkg::tll_rsp_t rsp,
   output logic low_limit_purge,
   output logic high_limit_purge,
   output logic warm_reset,
   output logic power_down_select,
   output logic [2:0] fault_queue_depth,
   output tll_pkg::tll_evt_t evt_latched,
   output logic [7:0] remote_low_limit_whole,
   output logic [3:0] remote_high_limit_fraction
);
   // ==========================================
   // State
   tll_pkg::tll_state_t state_r, state_nxt;
   tll_pkg::tll_rsp_t rsp_r, rsp_nxt;
   logic [7:0] low_whole_r, low_whole_nxt;
   logic [tll_pkg::LOCK_BITS-1:0] lock_r, lock_nxt;
   logic [tll_pkg::FRAC_BITS-1:0] res_frac_r, res_frac_nxt;
   logic [7:0] res_whole_r, res_whole_nxt;
   logic [tll_pkg::FRAC_BITS-1:0] high_frac_r, high_frac_nxt;
   logic low_purge_r, low_purge_nxt;
   logic high_purge_r, high_purge_nxt;
   logic warm_r, warm_nxt;
   logic pd_r, pd_nxt;
   logic [2:0] fq_r, fq_nxt;
   tll_pkg::tll_evt_t evt_r, evt_nxt;

   function automatic logic [2:0] fq_decode(input logic [1:0] code);
      case (code)
         2'b00: fq_decode = 3'h1;
         2'b01: fq_decode = 3'h2;
         2'b10: fq_decode = 3'h4;
         default: fq_decode = 3'h6;
      endcase
   endfunction

   function automatic logic is_write(input tll_pkg::tll_req_t r, input logic [7:0] c);
      is_write = r.valid && r.write && !r.word && (r.cmd == c);
   endfunction

   // ==========================================
   // Next state
   always_comb begin
      state_nxt = tll_pkg::TLL_IDLE;
      rsp_nxt = '0;
      low_whole_nxt = low_whole_r;
      lock_nxt = lock_r;
      res_frac_nxt = res_frac_r;
      res_whole_nxt = res_whole_r;
      high_frac_nxt = high_frac_r;
      low_purge_nxt = 1'b0;
      high_purge_nxt = 1'b0;
      warm_nxt = 1'b0;
      pd_nxt = pd_r;
      fq_nxt = fq_r;
      evt_nxt = evt_r;
      // Whole and fraction load together so a word read never mixes conversions.
      if (conv_done) begin
         res_whole_nxt = conv_whole;
         res_frac_nxt = conv_fraction;
      end
      if (is_write(req, tll_pkg::CMD_LOW_LIMIT_WHOLE)) begin
         low_whole_nxt = req.data;
         low_purge_nxt = 1'b1;
      end
      if (is_write(req, tll_pkg::CMD_HIGH_LIMIT_FRACTION)) begin
         high_frac_nxt = req.data[7:4];
         high_purge_nxt = 1'b1;
      end
      if (is_write(req, tll_pkg::CMD_SECURITY)) begin
         // Ones can only be added; a set bit clears only on reset or on a warm reset.
         lock_nxt = lock_r | req.data[tll_pkg::LOCK_BITS-1:0];
      end
      if (is_write(req, tll_pkg::CMD_CONFIG)) begin
         fq_nxt = fq_decode(req.data[tll_pkg::CFG_FQ_LSB +: 2]);
         if (!(req.data[tll_pkg::CFG_POWER_DOWN] && lock_r[tll_pkg::LOCK_POWER_DOWN])) begin
            pd_nxt = req.data[tll_pkg::CFG_POWER_DOWN];
         end
         low_purge_nxt = 1'b1;
         high_purge_nxt = 1'b1;
         if (req.data[tll_pkg::CFG_WARM_RESET] && !lock_r[tll_pkg::LOCK_WARM_RESET]) begin
            warm_nxt = 1'b1;
         end
      end
      // Events are held while their lock bit is set and follow the input otherwise.
      evt_nxt.diode = lock_r[tll_pkg::LOCK_DIODE] ? (evt_r.diode | evt_in.diode)
                                                  : evt_in.diode;
      evt_nxt.remote = lock_r[tll_pkg::LOCK_REMOTE] ? (evt_r.remote | evt_in.remote)
                                                    : evt_in.remote;
      evt_nxt.local_ot = lock_r[tll_pkg::LOCK_LOCAL] ? (evt_r.local_ot | evt_in.local_ot)
                                                     : evt_in.local_ot;
      if (req.valid && !req.write) begin
         state_nxt = tll_pkg::TLL_ANSWER;
         rsp_nxt.valid = 1'b1;
         if (req.word) begin
            // Only the whole result byte answers a word read; others return zero.
            if (req.cmd == tll_pkg::CMD_RESULT_WHOLE) begin
               rsp_nxt.data = {res_whole_r, res_frac_r, tll_pkg::FRAC_PAD};
            end
         end else begin
            case (req.cmd)
               tll_pkg::CMD_RESULT_WHOLE: rsp_nxt.data[7:0] = res_whole_r;
               tll_pkg::CMD_LOW_LIMIT_WHOLE: rsp_nxt.data[7:0] = low_whole_r;
               tll_pkg::CMD_SECURITY: rsp_nxt.data[7:0] = {tll_pkg::RESV_PAD, lock_r};
               tll_pkg::CMD_RESULT_FRACTION:
                  rsp_nxt.data[7:0] = {res_frac_r, tll_pkg::FRAC_PAD};
               tll_pkg::CMD_HIGH_LIMIT_FRACTION:
                  rsp_nxt.data[7:0] = {high_frac_r, tll_pkg::FRAC_PAD};
               default: rsp_nxt.data = '0;
            endcase
         end
      end
      // Warm reset returns this bank to defaults on the following cycle, lock bits included.
      if (warm_r) begin
         low_whole_nxt = tll_pkg::RESET_ZERO;
         high_frac_nxt = tll_pkg::FRAC_ZERO;
         res_frac_nxt = tll_pkg::FRAC_ZERO;
         res_whole_nxt = tll_pkg::RESET_ZERO;
         lock_nxt = tll_pkg::LOCK_NONE;
         pd_nxt = 1'b0;
         fq_nxt = fq_decode(2'b00);
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= tll_pkg::TLL_IDLE;
         rsp_r <= '0;
         low_whole_r <= tll_pkg::RESET_ZERO;
         lock_r <= tll_pkg::LOCK_NONE;
         res_frac_r <= tll_pkg::FRAC_ZERO;
         res_whole_r <= tll_pkg::RESET_ZERO;
         high_frac_r <= tll_pkg::FRAC_ZERO;
         low_purge_r <= 1'b0;
         high_purge_r <= 1'b0;
         warm_r <= 1'b0;
         pd_r <= 1'b0;
         fq_r <= 3'h1;
         evt_r <= '0;
      end else begin
         state_r <= state_nxt;
         rsp_r <= rsp_nxt;
         low_whole_r <= low_whole_nxt;
         lock_r <= lock_nxt;
         res_frac_r <= res_frac_nxt;
         res_whole_r <= res_whole_nxt;
         high_frac_r <= high_frac_nxt;
         low_purge_r <= low_purge_nxt;
         high_purge_r <= high_purge_nxt;
         warm_r <= warm_nxt;
         pd_r <= pd_nxt;
         fq_r <= fq_nxt;
         evt_r <= evt_nxt;
      end
   end

   assign rsp = rsp_r;
   assign low_limit_purge = low_purge_r;
   assign high_limit_purge = high_purge_r;
   assign warm_reset = warm_r;
   assign power_down_select = pd_r;
   assign fault_queue_depth = fq_r;
   assign evt_latched = evt_r;
   assign remote_low_limit_whole = low_whole_r;
   assign remote_high_limit_fraction = high_frac_r;
endmodule
`default_nettype wire

//--- verilog/tll_pkg.sv
// Package with command codes, field layouts and types for the thermal limit and lock registers.
package tll_pkg;
   // ==========================================
   // Command bytes
   localparam logic [7:0] CMD_RESULT_WHOLE = 8'h01;
   localparam logic [7:0] CMD_CONFIG = 8'h03;
   localparam logic [7:0] CMD_LOW_LIMIT_WHOLE = 8'h08;
   localparam logic [7:0] CMD_SECURITY = 8'h09;
   localparam logic [7:0] CMD_RESULT_FRACTION = 8'h10;
   localparam logic [7:0] CMD_HIGH_LIMIT_FRACTION = 8'h13;
   // ==========================================
   // Field layouts and reset values
   localparam int LOCK_WARM_RESET = 4;
   localparam int LOCK_POWER_DOWN = 3;
   localparam int LOCK_DIODE = 2;
   localparam int LOCK_REMOTE = 1;
   localparam int LOCK_LOCAL = 0;
   localparam int LOCK_BITS = 5;
   localparam int FRAC_BITS = 4;
   localparam int CFG_WARM_RESET = 0;
   localparam int CFG_POWER_DOWN = 6;
   localparam int CFG_FQ_LSB = 4;
   localparam logic [7:0] RESET_ZERO = 8'h00;
   localparam logic [LOCK_BITS-1:0] LOCK_NONE = 5'h00;
   localparam logic [FRAC_BITS-1:0] FRAC_ZERO = 4'h0;
   localparam logic [3:0] FRAC_PAD = 4'h0;
   localparam logic [2:0] RESV_PAD = 3'h0;
   // ==========================================
   // Types
   typedef struct packed {
      logic valid;
      logic write;
      logic word;
      logic [7:0] cmd;
      logic [7:0] data;
   } tll_req_t;
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } tll_rsp_t;
   typedef struct packed {
      logic diode;
      logic remote;
      logic local_ot;
   } tll_evt_t;
   typedef enum logic [1:0] {
      TLL_IDLE = 2'b00,
      TLL_ANSWER = 2'b01
   } tll_state_t;
endpackage

//--- testbench/tll_regs_monitor.sv
// Assertion checker for the limit and lock register bank.
`timescale 1ns/100ps
`default_nettype none
module tll_regs_monitor (
   input wire logic mclk,
   input wire logic rst,
   input wire tll_pkg::tll_req_t req,
   input wire logic conv_done,
   input wire logic [7:0] conv_whole,
   input wire logic [3:0] conv_fraction,
   input wire tll_pkg::tll_evt_t evt_in,
   input wire tll_pkg::tll_rsp_t rsp,
   input wire logic low_limit_purge,
   input wire logic high_limit_purge,
   input wire logic power_down_select,
   input wire logic [2:0] fault_queue_depth,
   input wire tll_pkg::tll_evt_t evt_latched,
   input wire logic [7:0] remote_low_limit_whole,
   input wire logic [3:0] remote_high_limit_fraction
);
   // ==========================================
   // Request decode
   logic rd, wr, cfg_wr;
   assign rd = req.valid && !req.write;
   assign wr = req.valid && req.write && !req.word;
   assign cfg_wr = wr && req.cmd == tll_pkg::CMD_CONFIG;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   chk_read_answer: assert property (rd |=> rsp.valid)
      else $error("read not answered");
   chk_write_quiet: assert property (wr |=> !rsp.valid)
      else $error("write answered");
   chk_low_store: assert property (wr && req.cmd == tll_pkg::CMD_LOW_LIMIT_WHOLE |=>
      low_limit_purge && remote_low_limit_whole == $past(req.data)) else $error("low limit");
   chk_high_store: assert property (wr && req.cmd == tll_pkg::CMD_HIGH_LIMIT_FRACTION |=>
      high_limit_purge && remote_high_limit_fraction == $past(req.data) >> 4)
      else $error("high fraction");
   chk_frac_pad: assert property (rd && !req.word && req.cmd[4] |=>
      rsp.data[3:0] == 4'h0 && rsp.data[15:8] == 8'h00) else $error("fraction pad");
   chk_word_pair: assert property (conv_done ##2 rd && req.word &&
      req.cmd == tll_pkg::CMD_RESULT_WHOLE |=>
      rsp.data == {$past(conv_whole, 3), $past(conv_fraction, 3), 4'h0}) else $error("word read");
   chk_depth_six: assert property (cfg_wr && req.data[5:4] == 2'b11 |=> fault_queue_depth == 3'h6)
      else $error("depth code");
   chk_shutdown_src: assert property ($rose(power_down_select) |-> $past(cfg_wr))
      else $error("shutdown source");
   chk_event_cause: assert property ($rose(evt_latched.diode) |-> $past(evt_in.diode))
      else $error("diode event");
endmodule
bind tll_regs tll_regs_monitor u_mon (.mclk, .rst, .req, .conv_done, .conv_whole, .conv_fraction,
   .evt_in, .rsp, .low_limit_purge, .high_limit_purge, .power_down_select, .fault_queue_depth,
   .evt_latched, .remote_low_limit_whole, .remote_high_limit_fraction);
`default_nettype wire

//--- testbench/tll_host_model.sv
// Host model that issues byte and word requests to the bank.
`timescale 1ns/100ps
`default_nettype none
module tll_host_model (
   input wire logic mclk,
   input wire tll_pkg::tll_rsp_t rsp,
   output tll_pkg::tll_req_t req
);
   initial req = '0;
   // Only one request is outstanding, so a slow answer never overlaps the next command.
   task automatic xfer(input logic w, input logic wd, input logic [7:0] c, input logic [7:0] d,
         output logic [15:0] q);
      int n;
      @(negedge mclk);
      req = '{1'b1, w, wd, c, (c == tll_pkg::CMD_SECURITY) ? (d & 8'h1F) : d};
      @(negedge mclk);
      req = '{1'b0, ~req.write, ~req.word, ~req.cmd, ~req.data};
      // The answer stands for one cycle from the taking edge itself, so look at once.
      for (n = 0; !w && rsp.valid !== 1'b1 && n < 4; n++) begin
         @(negedge mclk);
      end
      if (!w && rsp.valid !== 1'b1) begin
         tll_regs_tb_top.failures++;
         tll_regs_tb_top.wrap_up();
      end
      q = rsp.data;
   endtask
endmodule
`default_nettype wire

//--- testbench/tll_regs_tb_top.sv
// Self-checking bench for the limit and lock register bank.
`timescale 1ns/100ps
`default_nettype none
module tll_regs_tb_top;
   logic mclk = 1'b0, rst = 1'b1, conv_done = 1'b0;
   logic [7:0] conv_whole = 8'h3B;
   logic [3:0] conv_fraction = 4'h9;
   tll_pkg::tll_evt_t evt_in = '0, evt_latched;
   tll_pkg::tll_req_t req;
   tll_pkg::tll_rsp_t rsp;
   logic low_limit_purge, high_limit_purge, warm_reset, power_down_select;
   logic [2:0] fault_queue_depth;
   logic [7:0] remote_low_limit_whole;
   logic [3:0] remote_high_limit_fraction;
   logic [15:0] q;
   logic [2:0] depths [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
   logic [7:0] cmds [4] = '{tll_pkg::CMD_LOW_LIMIT_WHOLE, tll_pkg::CMD_SECURITY,
      tll_pkg::CMD_RESULT_FRACTION, tll_pkg::CMD_HIGH_LIMIT_FRACTION};
   int failures = 0, cmp_count = 0;
   always #12.5 mclk = ~mclk;
   tll_regs uut (.mclk, .rst, .req, .conv_done, .conv_whole, .conv_fraction, .evt_in, .rsp,
      .low_limit_purge, .high_limit_purge, .warm_reset, .power_down_select,
      .fault_queue_depth, .evt_latched, .remote_low_limit_whole, .remote_high_limit_fraction);
   tll_host_model host (.mclk, .rsp, .req);
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      host.xfer(1'b1, 1'b0, c, d, q);
   endtask
   task automatic rd(input logic wd, input logic [7:0] c, input logic [15:0] exp);
      host.xfer(1'b0, wd, c, 8'h00, q);
      chk("read data", q, exp);
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge mclk);
      rst = 1'b0;
      // ==========================================
      // Reset values and limit writes
      foreach (cmds[i]) rd(1'b0, cmds[i], 16'h0000);
      wr(tll_pkg::CMD_LOW_LIMIT_WHOLE, 8'hF6);
      chk("low purge", 16'(low_limit_purge), 16'h0001);
      rd(1'b0, tll_pkg::CMD_LOW_LIMIT_WHOLE, 16'h00F6);
      wr(tll_pkg::CMD_HIGH_LIMIT_FRACTION, 8'hFF);
      chk("high purge", 16'(high_limit_purge), 16'h0001);
      rd(1'b0, tll_pkg::CMD_HIGH_LIMIT_FRACTION, 16'h00F0);
      $display("Test limits done");
      // ==========================================
      // Conversion result
      @(negedge mclk) conv_done = 1'b1;
      @(negedge mclk) conv_done = 1'b0;
      rd(1'b1, tll_pkg::CMD_RESULT_WHOLE, 16'h3B90);
      rd(1'b0, tll_pkg::CMD_RESULT_FRACTION, 16'h0090);
      rd(1'b1, tll_pkg::CMD_LOW_LIMIT_WHOLE, 16'h0000);
      wr(tll_pkg::CMD_RESULT_FRACTION, 8'h50);
      rd(1'b0, tll_pkg::CMD_RESULT_FRACTION, 16'h0090);
      $display("Test result done");
      // ==========================================
      // Configuration, then locks
      for (int i = 0; i < 4; i++) begin
         wr(tll_pkg::CMD_CONFIG, 8'(i << 4));
         chk("depth", 16'(fault_queue_depth), 16'(depths[i]));
      end
      wr(tll_pkg::CMD_CONFIG, 8'h40);
      chk("shutdown", 16'(power_down_select), 16'h0001);
      wr(tll_pkg::CMD_CONFIG, 8'h01);
      chk("warm reset", 16'(warm_reset), 16'h0001);
      rd(1'b0, tll_pkg::CMD_LOW_LIMIT_WHOLE, 16'h0000);
      wr(tll_pkg::CMD_SECURITY, 8'h08);
      wr(tll_pkg::CMD_SECURITY, 8'h00);
      rd(1'b0, tll_pkg::CMD_SECURITY, 16'h0008);
      wr(tll_pkg::CMD_CONFIG, 8'h40);
      chk("shutdown", 16'(power_down_select), 16'h0000);
      wr(tll_pkg::CMD_SECURITY, 8'hF7);
      rd(1'b0, tll_pkg::CMD_SECURITY, 16'h001F);
      @(negedge mclk) evt_in = 3'b111;
      @(negedge mclk) evt_in = 3'b000;
      @(negedge mclk) chk("events", 16'(evt_latched), 16'h0007);
      wr(tll_pkg::CMD_CONFIG, 8'h01);
      chk("warm reset", 16'(warm_reset), 16'h0000);
      $display("Test locks done");
      wrap_up();
   end
endmodule
`default_nettype wire
